// *** prl_loader.sv ***
// Purpose: jump-to-ram boot select and timed parallel byte loader
// Assumes: one clock, async active-low reset, pins synchronised here
// Notes:   loaded words leave through a two-entry buffer with valid/ready
`default_nettype none
module prl_loader (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   nrst_i,
	// boot strap pins
	input  wire logic                   boot_select_2_i,
	input  wire logic                   boot_select_3_i,
	input  wire logic                   boot_select_4_i,
	// parallel source
	input  wire logic [7:0]             port_a_i,
	input  wire logic                   handshake_in_i,
	output logic                        handshake_out_o,
	output prl_pkg::prl_addr_pins_t     addr_pins_o,
	// status
	output logic                        jump_ram_o,
	output logic [14:0]                 start_addr_o,
	// loaded words
	output logic                        word_valid_o,
	output prl_pkg::prl_word_t          word_o,
	input  wire logic                   word_ready_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// two-flop synchronisers for every pin
	logic [7:0] data_s1_q, data_s2_q;
	logic [3:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			pin_s1_q  <= 4'h0;
			pin_s2_q  <= 4'h0;
		end else begin
			data_s1_q <= port_a_i;
			data_s2_q <= data_s1_q;
			pin_s1_q  <= {handshake_in_i, boot_select_4_i, boot_select_3_i, boot_select_2_i};
			pin_s2_q  <= pin_s1_q;
		end
	end
	// handshake input as seen after its synchroniser, two clocks behind the pin
	logic hs_in;
	assign hs_in = pin_s2_q[3];

	// boot level caught once after release; synchronised pins settle within two edges
	logic [1:0] boot_cnt_q, boot_cnt_d;
	logic       jump_q, jump_d;
	always_comb begin
		boot_cnt_d = boot_cnt_q;
		jump_d     = jump_q;
		if (boot_cnt_q != 2'd3) begin
			boot_cnt_d = boot_cnt_q + 2'd1;
			if (boot_cnt_q == 2'd2)
				jump_d = pin_s2_q[0] & pin_s2_q[1] & ~pin_s2_q[2];
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			boot_cnt_q <= 2'd0;
			jump_q     <= 1'b0;
		end else begin
			boot_cnt_q <= boot_cnt_d;
			jump_q     <= jump_d;
		end
	end
	assign jump_ram_o   = jump_q;
	assign start_addr_o = jump_q ? prl_pkg::RAM_START : prl_pkg::ADDR_RST;

	// machine-cycle tick; every interval below counts these ticks
	// divider shares the loader reset, so the first load cycle opens on a tick
	logic [7:0] div_q, div_d;
	logic       mc_tick;
	assign mc_tick = (div_q == 8'(prl_pkg::MC_DIV - 1));
	always_comb begin
		div_d = mc_tick ? 8'h00 : div_q + 8'h01;
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) div_q <= 8'h00;
		else         div_q <= div_d;
	end

	// two-entry output buffer
	prl_pkg::prl_word_t buf_q [2];
	prl_pkg::prl_word_t buf_d [2];
	logic [1:0] cnt_q, cnt_d;
	logic       push, pop, buf_ready;
	assign buf_ready    = (cnt_q != 2'd2);
	assign word_valid_o = (cnt_q != 2'd0);
	assign word_o       = buf_q[0];
	assign pop          = word_valid_o & word_ready_i;

	// load cycle sequencer
	prl_pkg::prl_state_t st_q, st_d;
	logic [5:0]  mc_q, mc_d;
	logic [14:0] addr_q, addr_d;
	logic        hs_out_q, hs_out_d;
	logic        hs_prev_q, hs_prev_d;
	logic        hs_seen_q, hs_seen_d;
	logic        late_q, late_d;
	logic [7:0]  cap_q, cap_d;
	logic        hs_mode;
	logic        hs_edge;
	assign hs_mode = (hs_in == hs_out_q) ? 1'b0 : 1'b1; // tied pins follow out two clocks late, through the synchroniser
	assign hs_edge = (hs_in != hs_prev_q);

	always_comb begin
		st_d      = st_q;
		mc_d      = mc_q;
		addr_d    = addr_q;
		hs_out_d  = hs_out_q;
		hs_prev_d = hs_in;
		hs_seen_d = hs_seen_q;
		late_d    = late_q;
		cap_d     = cap_q;
		push      = 1'b0;
		unique case (st_q)
			prl_pkg::PRL_IDLE: begin
				// loading only runs in the jump-to-ram level
				if (boot_cnt_q == 2'd3 && jump_q) begin
					st_d   = prl_pkg::PRL_WAIT;
					mc_d   = 6'd0;
					addr_d = prl_pkg::RAM_START;
				end
			end
			prl_pkg::PRL_WAIT: begin
				// a transition after the limit, unless seen in the push clock, is carried to the next cycle
				if (hs_edge && mc_q <= prl_pkg::T_EXR_MC && !hs_seen_q)
					hs_seen_d = 1'b1;
				else if (hs_edge)
					late_d = 1'b1;
				if (mc_tick) begin
					mc_d = mc_q + 6'd1;
					// data valid by the address-to-data limit, held past hold minimum
					// the tick closing cycle n-1 lands n cycles in, so capture stays in the hold
					if (mc_q == prl_pkg::T_ADR_MC + prl_pkg::T_DHR_MC - 6'd1)
						cap_d = data_s2_q;
					// same count-minus-one rule puts the toggle exactly at the delay
					if (mc_q == prl_pkg::T_HO_MC - 6'd1)
						hs_out_d = ~hs_out_q;
					if (mc_q == prl_pkg::T_CR_MC - 6'd1) begin
						if (buf_ready) begin
							push      = 1'b1;
							mc_d      = 6'd0;
							addr_d    = addr_q + 15'h0001;
							hs_seen_d = late_q;
							late_d    = 1'b0;
						end else
							mc_d = mc_q; // stall until the buffer has a free slot
					end
				end
				if (addr_q == 15'h7FFF && push)
					st_d = prl_pkg::PRL_DONE;
			end
			prl_pkg::PRL_DONE: st_d = prl_pkg::PRL_DONE;
			default:           st_d = prl_pkg::PRL_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q      <= prl_pkg::PRL_IDLE;
			mc_q      <= 6'd0;
			addr_q    <= prl_pkg::ADDR_RST;
			hs_out_q  <= 1'b0;
			hs_prev_q <= 1'b0;
			hs_seen_q <= 1'b0;
			late_q    <= 1'b0;
			cap_q     <= 8'h00;
		end else begin
			st_q      <= st_d;
			mc_q      <= mc_d;
			addr_q    <= addr_d;
			hs_out_q  <= hs_out_d;
			hs_prev_q <= hs_prev_d;
			hs_seen_q <= hs_seen_d;
			late_q    <= late_d;
			cap_q     <= cap_d;
		end
	end

	// buffer next state: pop shifts, push fills the first free slot
	always_comb begin
		buf_d[0] = buf_q[0];
		buf_d[1] = buf_q[1];
		cnt_d    = cnt_q;
		if (pop) begin
			buf_d[0] = buf_q[1];
			cnt_d    = cnt_q - 2'd1;
		end
		if (push) begin
			if (cnt_d == 2'd0) buf_d[0] = '{addr: addr_q, data: cap_q};
			else               buf_d[1] = '{addr: addr_q, data: cap_q};
			cnt_d = cnt_d + 2'd1;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			cnt_q    <= 2'd0;
		end else begin
			buf_q[0] <= buf_d[0];
			buf_q[1] <= buf_d[1];
			cnt_q    <= cnt_d;
		end
	end

	// address out on port b, port c low bits and compare pins
	assign addr_pins_o.port_b = addr_q[7:0];
	assign addr_pins_o.port_c = addr_q[12:8];
	assign addr_pins_o.cmp_a  = addr_q[13];
	assign addr_pins_o.cmp_b  = addr_q[14];
	assign handshake_out_o    = hs_out_q;
	// mode and early-edge flags are recorded only; loading is paced by time alone
	logic unused_hs;
	assign unused_hs = hs_mode ^ hs_seen_q;
endmodule // prl_loader
`default_nettype wire

// *** prl_pkg.sv ***
// Purpose: constants and carriers for the parallel ram loader
// Assumes: 50 MHz clk_i, machine cycle set by MC_DIV, 4 clk_i cycles
// Notes:   timing counts are in machine cycles, scaled to clk_i by the loader
//
// Functional notes
// - boot pins 2,3 high and 4 low at reset release select jump-to-ram at 0051.
// - without handshake each byte load cycle lasts 49 machine cycles.
// - handshake_out changes 5 machine cycles after its triggering event.
// - handshake transition counts this cycle only within 30 machine cycles.
// - all loader intervals come from a machine-cycle counter, one tick per 4 clk_i cycles; the boot level catch counts clk_i cycles instead.
// - 15-bit address on port b, port c low five bits, compare pins; data on port a.
`default_nettype none
package prl_pkg;
	localparam int          CLK_HZ        = 50_000_000;
	localparam int          MC_DIV        = 4;            // clk_i cycles per machine cycle
	localparam logic [5:0]  T_ADR_MC      = 6'd16;        // addr_to_data_delay
	localparam logic [5:0]  T_DHR_MC      = 6'd4;         // data_hold_min
	localparam logic [5:0]  T_CR_MC       = 6'd49;        // load_cycle_time
	localparam logic [5:0]  T_HO_MC       = 6'd5;         // handshake_out_delay
	localparam logic [5:0]  T_HI_MC       = 6'd10;        // handshake_in_hold
	localparam logic [5:0]  T_EXR_MC      = 6'd30;        // transition_recognise_limit
	localparam logic [14:0] RAM_START     = 15'h0051;
	localparam logic [14:0] ADDR_RST      = 15'h0000;

	typedef enum logic [1:0] {
		PRL_IDLE = 2'b00,
		PRL_WAIT = 2'b01,
		PRL_DONE = 2'b10
	} prl_state_t;

	// address as it leaves on the pins
	typedef struct packed {
		logic [7:0] port_b;
		logic [4:0] port_c;
		logic       cmp_a;
		logic       cmp_b;
	} prl_addr_pins_t;

	typedef struct packed {
		logic [14:0] addr;
		logic [7:0]  data;
	} prl_word_t;
endpackage : prl_pkg
`default_nettype wire

// *** prl_loader_properties.sv ***
// Purpose: port checks on prl_loader
// Assumes: one clock, nrst_i async low
// Notes:   a stall only stretches a cycle
`default_nettype none
module prl_loader_props (
	// watched ports
	input wire logic                    clk_i,
	input wire logic                    nrst_i,
	input wire logic                    handshake_out_o,
	input wire prl_pkg::prl_addr_pins_t addr_pins_o,
	input wire logic                    jump_ram_o,
	input wire logic [14:0]             start_addr_o,
	input wire logic                    word_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] a;
	logic [14:0] a_q;
	logic [8:0]  n_q;
	logic [2:0]  r_q;
	logic        mv;
	// n_q: cycles the address has stood, sticks at top so stalls cannot wrap it
	assign a = {addr_pins_o.cmp_b, addr_pins_o.cmp_a, addr_pins_o.port_c, addr_pins_o.port_b};
	assign mv = a != a_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			a_q <= '0;
			n_q <= '0;
			r_q <= '0;
		end else begin
			a_q <= a;
			n_q <= mv ? 9'h001 : n_q + {8'h00, ~&n_q};
			r_q <= r_q + {2'h0, ~&r_q};
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	start_value_a: assert property (start_addr_o == (jump_ram_o ? 15'h0051 : 15'h0000))
		else $error("start address");
	first_addr_a: assert property (mv && a_q == 0 |-> a == 15'h0051 && jump_ram_o)
		else $error("first address");
	idle_hold_a: assert property (!jump_ram_o |-> !word_valid_o && a == 0)
		else $error("idle loader moved");
	addr_step_a: assert property (mv && a_q != 0 |-> a == a_q + 15'h0001)
		else $error("address step");
	cycle_len_a: assert property (mv && a_q != 0 |-> n_q >= 9'd196)
		else $error("load cycle short");
	hs_delay_a: assert property ($changed(handshake_out_o) |-> n_q == 9'd20)
		else $error("handshake delay");
	strap_once_a: assert property ($changed(jump_ram_o) |-> r_q < 3'h6)
		else $error("boot level moved");
	cover property (word_valid_o);
	cover property ($changed(handshake_out_o));
	cover property (mv && a_q != 0);
endmodule // prl_loader_props
bind prl_loader prl_loader_props i_props (.clk_i, .nrst_i, .handshake_out_o, .addr_pins_o,
	.jump_ram_o, .start_addr_o, .word_valid_o);
`default_nettype wire

// *** prl_source.sv ***
// Purpose: eprom model on the loader pins
// Assumes: handshake looped back on the board
// Notes:   dly_i sets how slowly data follows
`default_nettype none
module prl_source (
	// pins
	input  wire logic                    clk_i,
	input  wire prl_pkg::prl_addr_pins_t addr_i,
	input  wire logic                    hs_out_i,
	input  wire logic [6:0]              dly_i,
	output logic [7:0]                   port_a_o,
	output logic                         hs_in_o
);
	timeunit 1ns;
	timeprecision 1ps;
	prl_pkg::prl_addr_pins_t a_q;
	logic [6:0]              age_q = '0;
	logic [7:0]              last_q = '0;
	// no handshake when fed from an eprom
	assign hs_in_o = hs_out_i;
	// until valid the bus toggles, so a stale byte never looks right
	assign port_a_o = (age_q >= dly_i) ? addr_i.port_b ^ 8'ha5 : ~last_q;
	always @(posedge clk_i) begin
		a_q <= addr_i;
		age_q <= (addr_i != a_q) ? '0 : age_q + {6'h00, ~&age_q};
		last_q <= port_a_o;
	end
endmodule // prl_source
`default_nettype wire

// *** parallel_ram_loader_handshake_test.sv ***
// Purpose: self-checking bench for prl_loader
// Assumes: prl_source stands in for the eprom
// Notes:   random ready stalls the word buffer
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %0t value mismatch got %h exp %h", $time, g, e); end end
module parallel_ram_loader_handshake_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk_i = 0, nrst_i = 0, rdy = 0, chk_len = 0;
	logic [2:0]              sel = 0;
	logic [6:0]              dly = 2;
	logic [31:0]             lf = 32'hc6a5;
	logic [7:0]              pa;
	logic                    hsi, hso, jmp, vld;
	logic [14:0]             sa;
	prl_pkg::prl_addr_pins_t ap, apq, hold;
	prl_pkg::prl_word_t      w;
	int                      miscompares = 0, n_checks = 0, cyc = 0, ln = 0, exp_a = 0;
	always #10 clk_i = ~clk_i;
	prl_source i_src (.clk_i, .addr_i(ap), .hs_out_i(hso), .dly_i(dly), .port_a_o(pa),
		.hs_in_o(hsi));
	prl_loader i_dut (.clk_i, .nrst_i, .boot_select_2_i(sel[0]), .boot_select_3_i(sel[1]),
		.boot_select_4_i(sel[2]), .port_a_i(pa), .handshake_in_i(hsi), .handshake_out_o(hso),
		.addr_pins_o(ap), .jump_ram_o(jmp), .start_addr_o(sa), .word_valid_o(vld), .word_o(w),
		.word_ready_i(rdy));
	// model: words leave in address order, one source byte each; cycle length measured
	always @(posedge clk_i) begin
		if (nrst_i && vld && rdy) begin
			`CHK(w, {exp_a[14:0], exp_a[7:0] ^ 8'ha5})
			exp_a++;
		end
		if (ap !== apq) begin
			if (chk_len && apq !== '0) `CHK(ln, 196)
			ln = 1;
		end else ln++;
		apq = ap;
		// ceiling last in the block so nothing runs after the report
		if (++cyc == 9000) begin
			miscompares++;
			final_report();
		end
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic rst(input logic [2:0] s);
		nrst_i = 0;
		sel = s;
		tick(4);
		nrst_i = 1;
	endtask
	// straps, then steady, slow, random and stalled loading
	initial begin
		#2;
		for (int i = 0; i < 8; i++) begin
			rst(i[2:0]);
			for (int k = 0; k < 2; k++) begin
				tick(12);
				`CHK(jmp, 1'(i == 3))
				`CHK(sa, i == 3 ? 15'h0051 : 15'h0000)
				sel = ~sel;
			end
		end
		exp_a = 'h51;
		rst(3'h3);
		rdy = 1;
		chk_len = 1;
		tick(800);
		dly = 60;
		tick(800);
		chk_len = 0;
		repeat (800) begin
			tick(1);
			lf = nxt(lf);
			rdy = lf[0];
		end
		rdy = 0;
		tick(700);
		hold = ap;
		tick(200);
		`CHK(ap, hold)
		rdy = 1;
		tick(600);
		`CHK(exp_a > 'h5c, 1'b1)
		final_report();
	end
	task automatic final_report;
		$display("n_checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
endmodule // parallel_ram_loader_handshake_test
`default_nettype wire
